// ### include/sdcd_pkg.sv
// Constants and types shared by the SDRAM command decoder
package sdcd_pkg;

   // Pin widths and counts
   localparam int BA_W      = 3;
   localparam int ADDR_W    = 16;
   localparam int NUM_BANKS = 8;
   localparam int NUM_MR    = 4;
   localparam int MR_SEL_W  = 2;
   localparam int PIN_W     = 5 + BA_W + ADDR_W;
   localparam int COL_W     = 11;
   localparam int TMR_W     = 8;
   localparam int BURST_W   = 3;
   localparam int TICK_W    = 10;
   localparam int ST_W      = 5;

   // Address bit positions
   localparam int A10_POS = 10;
   localparam int A11_POS = 11;
   localparam int A12_POS = 12;

   // Burst field in mode register zero
   localparam int MR0_BL_LSB = 0;
   localparam int MR0_BL_MSB = 1;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [ADDR_W-1:0] MR_RST = 16'h0000;

   // Burst durations in clocks, two beats per clock
   localparam logic [BURST_W-1:0] BL8_CLKS = 3'h4;
   localparam logic [BURST_W-1:0] BC4_CLKS = 3'h2;

   // Average refresh interval used inside self refresh
   localparam int CLK_PERIOD_PS = 8000;
   localparam int TREFI_PS      = 7800000;
   localparam logic [TICK_W-1:0] TREFI_CLKS = TICK_W'(TREFI_PS / CLK_PERIOD_PS);

   // Idle levels of the pins: deselected, CKE low
   localparam logic [PIN_W-1:0] PIN_IDLE = {5'h1e, {(BA_W + ADDR_W){1'b0}}};

   // Command codes of RAS#, CAS#, WE#
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_ZQ  = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;

   // Power states
   typedef enum logic [ST_W-1:0] {
      ST_NORM   = 5'h01,
      ST_PD_ACT = 5'h02,
      ST_PD_PRE = 5'h04,
      ST_PD     = 5'h08,
      ST_SREF   = 5'h10
   } sdcd_state_t;

endpackage : sdcd_pkg

// ### hdl/sdcd_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module sdcd_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule : sdcd_sync

// ### hdl/sdcd_decode.sv
// SDRAM command decoder with CKE power state tracking
`timescale 1ns/100ps
module sdcd_decode
   import sdcd_pkg::*;
#(
   parameter logic [TMR_W-1:0] REF_CLKS = 8'h20,
   parameter logic [TMR_W-1:0] PRE_CLKS = 8'h04,
   parameter logic [TMR_W-1:0] XP_CLKS  = 8'h04
)(
   input  wire logic                 CLK_SYS,
   input  wire logic                 RST_B,
   input  wire logic                 CS_B,
   input  wire logic                 RAS_B,
   input  wire logic                 CAS_B,
   input  wire logic                 WE_B,
   input  wire logic                 CKE,
   input  wire logic [BA_W-1:0]      BA,
   input  wire logic [ADDR_W-1:0]    ADDR,
   output logic      [ST_W-1:0]      STATE,
   output logic                      IDLE,
   output logic                      CMD_MRS,
   output logic                      CMD_REF,
   output logic                      CMD_ACT,
   output logic                      CMD_RD,
   output logic                      CMD_WR,
   output logic                      CMD_PRE,
   output logic                      CMD_ZQL,
   output logic                      CMD_ZQS,
   output logic                      CMD_ZQ_INIT,
   output logic      [BA_W-1:0]      CMD_BANK,
   output logic      [ADDR_W-1:0]    CMD_ADDR,
   output logic      [COL_W-1:0]     CMD_COL,
   output logic                      CMD_AUTOPRE,
   output logic                      CMD_CHOP,
   output logic      [NUM_BANKS-1:0] PRE_MASK,
   output logic      [NUM_BANKS-1:0] BANK_OPEN,
   output logic                      BURST_BUSY,
   output logic                      REF_BUSY,
   output logic      [ADDR_W-1:0]    REF_ROW,
   output logic      [ADDR_W-1:0]    MODE_REG0,
   output logic      [ADDR_W-1:0]    MODE_REG1,
   output logic      [ADDR_W-1:0]    MODE_REG2,
   output logic      [ADDR_W-1:0]    MODE_REG3
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin capture

   logic [PIN_W-1:0]   pin_s;
   logic               cs_b;
   logic               ras_b;
   logic               cas_b;
   logic               we_b;
   logic               cke_now;
   logic [BA_W-1:0]    ba;
   logic [ADDR_W-1:0]  addr;
   logic [2:0]         cmd;

   // Pins cross into the clock domain before decoding
   sdcd_sync #(
      .WIDTH   (PIN_W),
      .RST_VAL (PIN_IDLE)
   ) u_pin_sync (
      .clk   (CLK_SYS),
      .rst_b (RST_B),
      .din   ({CS_B, RAS_B, CAS_B, WE_B, CKE, BA, ADDR}),
      .dout  (pin_s)
   );

   // Termination control has no input here, so it cannot sway decode
   assign {cs_b, ras_b, cas_b, we_b, cke_now, ba, addr} = pin_s;
   assign cmd = {ras_b, cas_b, we_b};

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   sdcd_state_t          state_ff;
   sdcd_state_t          nxt_state;
   logic                 cke_prev_ff;
   logic [ADDR_W-1:0]    mode_reg_ff [NUM_MR];
   logic [NUM_BANKS-1:0] bank_open_ff;
   logic [NUM_BANKS-1:0] nxt_bank_open;
   logic [BURST_W-1:0]   burst_cnt_ff;
   logic                 ap_pend_ff;
   logic [BA_W-1:0]      ap_bank_ff;
   logic [TMR_W-1:0]     pre_cnt_ff;
   logic [TMR_W-1:0]     ref_cnt_ff;
   logic [TMR_W-1:0]     xp_cnt_ff;
   logic [TICK_W-1:0]    sref_tick_ff;
   logic [ADDR_W-1:0]    ref_row_ff;
   logic                 zq_done_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   logic                 in_norm;
   logic                 nop_des;
   logic                 cmd_ok;
   logic                 is_mrs;
   logic                 is_ref;
   logic                 is_pre;
   logic                 is_act;
   logic                 is_zq;
   logic                 is_rw;
   logic                 chop;
   logic                 burst_end;
   logic                 quiet;
   logic                 cke_fall;
   logic                 cke_rise;
   logic                 sref_tick;
   logic [NUM_BANKS-1:0] pre_mask;

   // Deselect or no-operation: nothing new starts
   assign nop_des = cs_b | (cmd == CMD_NOP);
   assign in_norm = (state_ff == ST_NORM);

   // Commands only with select low and CKE high on both edges
   assign cmd_ok = in_norm & cke_prev_ff & cke_now & ~cs_b;

   // Strobe code table; pulse ports share the code names, so codes are scoped
   assign is_mrs = cmd_ok & (cmd == sdcd_pkg::CMD_MRS);
   assign is_ref = cmd_ok & (cmd == sdcd_pkg::CMD_REF);
   assign is_pre = cmd_ok & (cmd == sdcd_pkg::CMD_PRE);
   assign is_act = cmd_ok & (cmd == sdcd_pkg::CMD_ACT);
   assign is_zq  = cmd_ok & (cmd == CMD_ZQ);

   // A new burst is not taken while one is running
   assign is_rw = cmd_ok & ((cmd == sdcd_pkg::CMD_RD) | (cmd == sdcd_pkg::CMD_WR))
                & (burst_cnt_ff == '0);

   // Burst length from mode register zero and A12
   always_comb begin
      unique case (mode_reg_ff[0][MR0_BL_MSB:MR0_BL_LSB])
         BL_FIXED8: chop = 1'b0;
         BL_OTF:    chop = ~addr[A12_POS];
         BL_FIXED4: chop = 1'b1;
         default:   chop = 1'b0;
      endcase
   end

   // Quiet: banks closed, no burst, all timers expired
   assign quiet = (bank_open_ff == '0) & (burst_cnt_ff == '0) & (pre_cnt_ff == '0)
                & (ref_cnt_ff == '0) & (xp_cnt_ff == '0);
   assign IDLE  = quiet & cke_now & in_norm;

   // CKE edges from samples at n-1 and n
   assign cke_fall  = in_norm & cke_prev_ff & ~cke_now;
   assign cke_rise  = ~cke_prev_ff & cke_now;
   assign burst_end = (burst_cnt_ff == BURST_W'(1));
   assign sref_tick = (state_ff == ST_SREF) & (sref_tick_ff == TREFI_CLKS - TICK_W'(1));

   // Precharge target: one bank or all banks
   always_comb begin
      pre_mask = '0;
      if (addr[A10_POS]) begin
         pre_mask = '1;
      end else begin
         pre_mask[ba] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine

   // Next power state from current state and CKE pair
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_NORM: begin
            if (cke_fall) begin
               if (!cs_b && cmd == sdcd_pkg::CMD_REF && quiet) begin
                  nxt_state = ST_SREF;
               end else if (nop_des) begin
                  if (bank_open_ff != '0) begin
                     nxt_state = ST_PD_ACT;
                  end else if (burst_cnt_ff != '0 || pre_cnt_ff != '0) begin
                     nxt_state = ST_PD;
                  end else begin
                     nxt_state = ST_PD_PRE;
                  end
               end
            end
         end
         ST_PD_ACT, ST_PD_PRE, ST_PD: begin
            // CKE low twice holds; rise with deselect or no-op exits
            if (cke_rise && nop_des) begin
               nxt_state = ST_NORM;
            end
         end
         ST_SREF: begin
            // Exit taken on CKE alone, command pins not decoded
            if (cke_now) begin
               nxt_state = ST_NORM;
            end
         end
         default: nxt_state = ST_NORM;
      endcase
   end

   // State and previous CKE; reset pin loads ST_NORM and clears previous CKE
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_ff    <= ST_NORM;
         cke_prev_ff <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         cke_prev_ff <= cke_now;
      end
   end

   // Exit timer holds off idle after power-down or self refresh
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         xp_cnt_ff <= '0;
      end else if (!in_norm && nxt_state == ST_NORM) begin
         xp_cnt_ff <= XP_CLKS;
      end else if (xp_cnt_ff != '0) begin
         xp_cnt_ff <= xp_cnt_ff - TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode registers

   // Bank address picks one of four registers
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < NUM_MR; i++) begin
            mode_reg_ff[i] <= MR_RST;
         end
      end else if (is_mrs) begin
         mode_reg_ff[ba[MR_SEL_W-1:0]] <= addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Banks, bursts and precharge

   // Open the addressed bank; close the addressed bank, or all banks on precharge with A10
   always_comb begin
      nxt_bank_open = bank_open_ff;
      if (burst_end && ap_pend_ff) begin
         nxt_bank_open[ap_bank_ff] = 1'b0;
      end
      if (is_pre) begin
         nxt_bank_open = nxt_bank_open & ~pre_mask;
      end
      if (is_act) begin
         nxt_bank_open[ba] = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         bank_open_ff <= '0;
      end else begin
         bank_open_ff <= nxt_bank_open;
      end
   end

   // Burst counter runs out even through power-down
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         burst_cnt_ff <= '0;
         ap_pend_ff   <= 1'b0;
         ap_bank_ff   <= '0;
      end else if (is_rw) begin
         burst_cnt_ff <= chop ? BC4_CLKS : BL8_CLKS;
         ap_pend_ff   <= addr[A10_POS];
         ap_bank_ff   <= ba;
      end else if (burst_cnt_ff != '0) begin
         burst_cnt_ff <= burst_cnt_ff - BURST_W'(1);
         if (burst_end) begin
            ap_pend_ff <= 1'b0;
         end
      end
   end

   // Precharge busy time after explicit or auto precharge
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         pre_cnt_ff <= '0;
      end else if (is_pre || (burst_end && ap_pend_ff)) begin
         pre_cnt_ff <= PRE_CLKS;
      end else if (pre_cnt_ff != '0) begin
         pre_cnt_ff <= pre_cnt_ff - TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refresh

   // Refresh busy time from a refresh command
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ref_cnt_ff <= '0;
      end else if (is_ref) begin
         ref_cnt_ff <= REF_CLKS;
      end else if (ref_cnt_ff != '0) begin
         ref_cnt_ff <= ref_cnt_ff - TMR_W'(1);
      end
   end

   // Internal refresh ticks only in self refresh, never in power-down
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         sref_tick_ff <= '0;
      end else if (state_ff != ST_SREF || sref_tick) begin
         sref_tick_ff <= '0;
      end else begin
         sref_tick_ff <= sref_tick_ff + TICK_W'(1);
      end
   end

   // Row address comes from this counter, not the address pins
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ref_row_ff <= '0;
      end else if (is_ref || sref_tick) begin
         ref_row_ff <= ref_row_ff + ADDR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration

   // First long calibration is the initial one
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         zq_done_ff <= 1'b0;
      end else if (is_zq && addr[A10_POS]) begin
         zq_done_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command outputs

   // One-cycle command pulses
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         CMD_MRS     <= 1'b0;
         CMD_REF     <= 1'b0;
         CMD_ACT     <= 1'b0;
         CMD_RD      <= 1'b0;
         CMD_WR      <= 1'b0;
         CMD_PRE     <= 1'b0;
         CMD_ZQL     <= 1'b0;
         CMD_ZQS     <= 1'b0;
         CMD_ZQ_INIT <= 1'b0;
      end else begin
         CMD_MRS     <= is_mrs;
         CMD_REF     <= is_ref;
         CMD_ACT     <= is_act;
         CMD_RD      <= is_rw & (cmd == sdcd_pkg::CMD_RD);
         CMD_WR      <= is_rw & (cmd == sdcd_pkg::CMD_WR);
         CMD_PRE     <= is_pre;
         CMD_ZQL     <= is_zq & addr[A10_POS];
         CMD_ZQS     <= is_zq & ~addr[A10_POS];
         CMD_ZQ_INIT <= is_zq & addr[A10_POS] & ~zq_done_ff;
      end
   end

   // Command fields held until the next select with CKE high, no-ops and refused bursts included
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         CMD_BANK    <= '0;
         CMD_ADDR    <= '0;
         CMD_COL     <= '0;
         CMD_AUTOPRE <= 1'b0;
         CMD_CHOP    <= 1'b0;
         PRE_MASK    <= '0;
      end else if (cmd_ok) begin
         CMD_BANK    <= ba;
         CMD_ADDR    <= addr;
         CMD_COL     <= {addr[A11_POS], addr[A10_POS-1:0]};
         CMD_AUTOPRE <= is_rw & addr[A10_POS];
         CMD_CHOP    <= is_rw & chop;
         PRE_MASK    <= is_pre ? pre_mask : '0;
      end
   end

   // Status views of internal registers
   assign STATE      = state_ff;
   assign BANK_OPEN  = bank_open_ff;
   assign BURST_BUSY = (burst_cnt_ff != '0);
   assign REF_BUSY   = (ref_cnt_ff != '0);
   assign REF_ROW    = ref_row_ff;
   assign MODE_REG0  = mode_reg_ff[0];
   assign MODE_REG1  = mode_reg_ff[1];
   assign MODE_REG2  = mode_reg_ff[2];
   assign MODE_REG3  = mode_reg_ff[3];

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   // Select with all strobes high starts nothing
   property p_nop_quiet;
      (!cs_b && cmd == CMD_NOP) |=> !(CMD_MRS || CMD_REF || CMD_ACT || CMD_RD
                                     || CMD_WR || CMD_PRE || CMD_ZQL || CMD_ZQS);
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("NOP started a command");

   // Deselect executes no mode, refresh, activate, read, write or precharge, whatever the strobes
   property p_des_quiet;
      cs_b |=> !(CMD_MRS || CMD_REF || CMD_ACT || CMD_RD || CMD_WR || CMD_PRE);
   endproperty
   a_des_quiet: assert property (p_des_quiet) else $error("Deselect ran a command");

   // Mode register set loads the selected register with the opcode
   property p_mrs_load;
      is_mrs |=> (mode_reg_ff[$past(ba[MR_SEL_W-1:0])] == $past(addr)) && CMD_MRS;
   endproperty
   a_mrs_load: assert property (p_mrs_load) else $error("Mode register not loaded");

   // An eight-beat burst counts down to its end without being cut
   property p_burst_run;
      (burst_cnt_ff == BL8_CLKS) |=> (burst_cnt_ff == BL8_CLKS - BURST_W'(1)) ##1
                                   (burst_cnt_ff == BC4_CLKS) ##1 BURST_BUSY ##1 !BURST_BUSY;
   endproperty
   a_burst_run: assert property (p_burst_run) else $error("Burst cut short");

   // On-the-fly mode with A12 low gives a chopped burst
   property p_otf_chop;
      (is_rw && mode_reg_ff[0][MR0_BL_MSB:MR0_BL_LSB] == BL_OTF && !addr[A12_POS])
         |=> CMD_CHOP && burst_cnt_ff == BC4_CLKS;
   endproperty
   a_otf_chop: assert property (p_otf_chop) else $error("Chop not selected");

   // Refresh with CKE falling from quiet enters self refresh
   property p_sref_entry;
      (cke_fall && !cs_b && cmd == sdcd_pkg::CMD_REF && quiet) |=> state_ff == ST_SREF;
   endproperty
   a_sref_entry: assert property (p_sref_entry) else $error("No self refresh");

   // CKE low on two edges keeps the low power state
   property p_pd_hold;
      (!in_norm && !cke_prev_ff && !cke_now) |=> state_ff == $past(state_ff);
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("Low power state left");

   // Power-down never advances the refresh row
   property p_pd_no_ref;
      (state_ff == ST_PD_ACT || state_ff == ST_PD_PRE || state_ff == ST_PD)
         |=> $stable(ref_row_ff);
   endproperty
   a_pd_no_ref: assert property (p_pd_no_ref) else $error("Refresh in power-down");

   // Self refresh ends on CKE high alone
   property p_sref_exit;
      (state_ff == ST_SREF && cke_now) |=> in_norm ##1 !IDLE;
   endproperty
   a_sref_exit: assert property (p_sref_exit) else $error("Self refresh exit missed");

   // Precharge all closes every bank
   property p_pre_all;
      (is_pre && addr[A10_POS]) |=> BANK_OPEN == '0 && PRE_MASK == '1;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("Banks left open");

endmodule : sdcd_decode

// ### test/sdcd_ctrl_model.sv
// Controller model that drives the command and address pins
`timescale 1ns/100ps
module sdcd_ctrl_model
   import sdcd_pkg::*;
(
   input  wire logic              clk,
   output logic                   cs_b,
   output logic                   ras_b,
   output logic                   cas_b,
   output logic                   we_b,
   output logic                   cke,
   output logic      [BA_W-1:0]   ba,
   output logic      [ADDR_W-1:0] addr
);
   // Deselected with CKE low until the first request
   initial begin
      {cs_b, ras_b, cas_b, we_b, cke} = 5'h1e;
      {ba, addr} = '0;
   end

   // One command for one edge, then deselect; released pins show the inverse
   task automatic send(input logic [3:0] c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic k);
      @(posedge clk);
      {cs_b, ras_b, cas_b, we_b} <= c;
      ba   <= b;
      addr <= a;
      cke  <= k;
      @(posedge clk);
      {cs_b, ras_b, cas_b, we_b} <= 4'hf;
      ba   <= ~b;
      addr <= ~a;
   endtask : send
endmodule : sdcd_ctrl_model

// ### test/tb_top.sv
// Self-checking bench for the SDRAM command decoder
`timescale 1ns/100ps
module tb_top
   import sdcd_pkg::*;
;
   logic                 CLK_SYS = 1'b0;
   logic                 RST_B   = 1'b0;
   logic                 cs_b, ras_b, cas_b, we_b, cke, idle, ap, chop, busy, rbusy;
   logic [BA_W-1:0]      ba, bnk, cbank;
   logic [ADDR_W-1:0]    addr, v, m0, m1, m2, m3, rrow, caddr;
   logic [COL_W-1:0]     col;
   logic [ADDR_W-1:0]    mr [NUM_MR];
   logic [ST_W-1:0]      state;
   logic [8:0]           p;
   logic [NUM_BANKS-1:0] pmask, bopen;
   logic [15:0]          seen;
   logic [15:0]          exp_q [$];
   int                   n_mismatch = 0;
   int                   n_tests    = 0;

   // Clock of 8 ns
   always #4 CLK_SYS = ~CLK_SYS;

   sdcd_ctrl_model u_ctrl (.clk(CLK_SYS), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
      .we_b(we_b), .cke(cke), .ba(ba), .addr(addr));

   sdcd_decode #(.REF_CLKS(8'h08), .PRE_CLKS(8'h02), .XP_CLKS(8'h02)) u_dut (
      .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CS_B(cs_b), .RAS_B(ras_b), .CAS_B(cas_b),
      .WE_B(we_b), .CKE(cke), .BA(ba), .ADDR(addr), .STATE(state), .IDLE(idle),
      .CMD_MRS(p[8]), .CMD_REF(p[7]), .CMD_ACT(p[6]), .CMD_RD(p[5]), .CMD_WR(p[4]),
      .CMD_PRE(p[3]), .CMD_ZQL(p[2]), .CMD_ZQS(p[1]), .CMD_ZQ_INIT(p[0]),
      .CMD_BANK(cbank), .CMD_ADDR(caddr), .CMD_COL(col), .CMD_AUTOPRE(ap), .CMD_CHOP(chop),
      .PRE_MASK(pmask), .BANK_OPEN(bopen), .BURST_BUSY(busy), .REF_BUSY(rbusy),
      .REF_ROW(rrow), .MODE_REG0(m0), .MODE_REG1(m1), .MODE_REG2(m2), .MODE_REG3(m3));

   // Burst fields only matter on reads and writes
   assign seen = {2'h0, p, cbank, ap & (p[5] | p[4]), chop & (p[5] | p[4])};

   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic note(input logic [8:0] q, input logic [BA_W-1:0] b, input logic a, c);
      exp_q.push_back({2'h0, q, b, a, c});
   endtask : note

   task automatic settle(input string t);
      repeat (6) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      $display("Test %s done", t);
   endtask : settle

   task automatic wait_idle();
      int t;
      t = 0;
      while (idle !== 1'b1 && t < 100) begin
         @(negedge CLK_SYS);
         t++;
      end
      check("idle", 16'(idle), 16'h0001);
      if (t == 100) end_of_test();
   endtask : wait_idle

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // Oldest note is compared whenever a command pulse appears
   always @(negedge CLK_SYS) begin
      if ((|p) === 1'b1) begin
         if (exp_q.size() > 0) check("cmd", seen, exp_q.pop_front());
         else check("cmd", seen, 16'h0000);
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      void'($urandom(95));
      repeat (5) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      u_ctrl.send(4'hf, 3'h0, 16'h0000, 1'b1);
      // Load all four mode registers, zero with on-the-fly bursts
      for (int i = 0; i < NUM_MR; i++) begin
         v = 16'($urandom);
         if (i == 0) v[MR0_BL_MSB:MR0_BL_LSB] = BL_OTF;
         mr[i] = v;
         u_ctrl.send(4'h0, 3'(i), v, 1'b1);
         note(9'h100, 3'(i), 1'b0, 1'b0);
      end
      settle("mode");
      check("mr0", m0, mr[0]);
      check("mr1", m1, mr[1]);
      check("mr2", m2, mr[2]);
      check("mr3", m3, mr[3]);
      check("addr", caddr, mr[3]);
      check("col", 16'(col), 16'({mr[3][A11_POS], mr[3][A10_POS-1:0]}));
      bnk = 3'($urandom);
      u_ctrl.send(4'h3, bnk, 16'($urandom), 1'b1);
      note(9'h040, bnk, 1'b0, 1'b0);
      settle("activate");
      check("open", 16'(bopen), 16'(8'h01 << bnk));
      // Eight-beat read with auto precharge, then one inside its burst
      u_ctrl.send(4'h5, bnk, 16'h1400, 1'b1);
      note(9'h020, bnk, 1'b1, 1'b0);
      u_ctrl.send(4'h5, bnk, 16'h1000, 1'b1);
      @(negedge CLK_SYS);
      check("busy", 16'(busy), 16'h0001);
      settle("read");
      check("open", 16'(bopen), 16'h0000);
      u_ctrl.send(4'h3, bnk, 16'h0000, 1'b1);
      note(9'h040, bnk, 1'b0, 1'b0);
      u_ctrl.send(4'h4, bnk, 16'h0000, 1'b1);
      note(9'h010, bnk, 1'b0, 1'b1);
      repeat (4) @(posedge CLK_SYS);
      u_ctrl.send(4'h2, ~bnk, 16'h0400, 1'b1);
      note(9'h008, ~bnk, 1'b0, 1'b0);
      settle("write");
      check("mask", 16'(pmask), 16'h00ff);
      // Calibration long twice then short, refresh, and two non-commands
      u_ctrl.send(4'h6, 3'h0, 16'h0400, 1'b1);
      note(9'h005, 3'h0, 1'b0, 1'b0);
      u_ctrl.send(4'h6, 3'h1, 16'hffff, 1'b1);
      note(9'h004, 3'h1, 1'b0, 1'b0);
      u_ctrl.send(4'h6, 3'h2, 16'hfbff, 1'b1);
      note(9'h002, 3'h2, 1'b0, 1'b0);
      u_ctrl.send(4'h1, 3'h3, 16'($urandom), 1'b1);
      note(9'h080, 3'h3, 1'b0, 1'b0);
      u_ctrl.send(4'h7, 3'h4, 16'h0000, 1'b1);
      @(negedge CLK_SYS);
      check("rbusy", 16'(rbusy), 16'h0001);
      u_ctrl.send(4'h8, 3'h0, 16'h0000, 1'b1);
      settle("calibrate");
      check("mr0", m0, mr[0]);
      check("row", rrow, 16'h0001);
      // Fixed four-beat mode chops even with A12 high
      mr[0] = 16'(BL_FIXED4);
      u_ctrl.send(4'h0, 3'h0, mr[0], 1'b1);
      note(9'h100, 3'h0, 1'b0, 1'b0);
      u_ctrl.send(4'h3, bnk, 16'h0000, 1'b1);
      note(9'h040, bnk, 1'b0, 1'b0);
      u_ctrl.send(4'h5, bnk, 16'h1400, 1'b1);
      note(9'h020, bnk, 1'b1, 1'b1);
      settle("fixed chop");
      check("open", 16'(bopen), 16'h0000);
      // Power-down from idle, then with a bank open
      for (int k = 0; k < 2; k++) begin
         if (k == 0) wait_idle();
         else u_ctrl.send(4'h3, bnk, 16'h0000, 1'b1);
         if (k == 1) note(9'h040, bnk, 1'b0, 1'b0);
         u_ctrl.send(4'h7, 3'h0, 16'h0000, 1'b0);
         settle("pd entry");
         check("state", 16'(state), k ? 16'h0002 : 16'h0004);
         u_ctrl.send(4'h0, 3'h0, 16'h0000, 1'b0);
         settle("pd hold");
         check("state", 16'(state), k ? 16'h0002 : 16'h0004);
         u_ctrl.send(4'hf, 3'h0, 16'h0000, 1'b1);
         settle("pd exit");
         check("state", 16'(state), 16'h0001);
      end
      u_ctrl.send(4'h2, bnk, 16'h0000, 1'b1);
      note(9'h008, bnk, 1'b0, 1'b0);
      wait_idle();
      check("mask", 16'(pmask), 16'(8'h01 << bnk));
      u_ctrl.send(4'h1, 3'h0, 16'h0000, 1'b0);
      settle("sref entry");
      check("state", 16'(state), 16'h0010);
      u_ctrl.send(4'hf, 3'h0, 16'h0000, 1'b1);
      settle("sref exit");
      check("state", 16'(state), 16'h0001);
      check("notes", 16'(exp_q.size()), 16'h0000);
      end_of_test();
   end
endmodule : tb_top
